// [logic/brsc_core.v]
// Board reset classification, soft reset state and front panel lamps
`timescale 1ns/1ps
`include "brsc_defs.vh"

// ==================================================
// Summary of operation
// - Supply between three and four and a half volts gives warm reset.
// - Supply below three volts gives cold reset driving bus reset; power-on resets without driving it.
// - Warm reset keeps config bits 7:4 and module control bits 1,2,4,6.
// - Warm reset drives bus reset only if bit 6 set; watchdog always drives.
// - Keyboard sequence is a software reset only, nothing hardware happens.
// - Front button causes warm reset then self-test and reload.
// - Bus reset with input enable set acts as button reset.
// - Watchdog reset like button, failure line held until flag cleared.
// - Hardware reset clears registers; power-on clears arbiter fields too.
// - Soft request clears interrupt generator, master, watchdog, pass; sets events.
// - Soft state asserts failure line unless inhibit bit is set.
// - Slot-one control and bus timeout ignore the soft request.
// - Soft state left by button, power-on, writing zero, enabled bus reset.
// - Clearing soft request restores master enable and restarts watchdog count.
// - Bus timeout sets timeout event alone; soft entry sets both.
// - Bus reset with input enable clear enters soft state keeping pass.
// - Run lamp lights on DRAM writes.
// - Fail lamp follows bus failure line as slot one, and after hardware reset.
// - Test lamp lit exactly while pass bit is zero.

module brsc_core #(
  parameter HOLD_CYCLES = (`BRSC_RESET_HOLD_NS + `BRSC_CLK_PERIOD_NS - 1) /
                          `BRSC_CLK_PERIOD_NS
) (
  // Clock and power-on reset
  input  wire        clk,
  input  wire        rst_n,
  // Register port
  input  wire [15:0] reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  // Asynchronous pins
  input  wire        supply_low_n,
  input  wire        supply_dead_n,
  input  wire        button_n,
  input  wire        bus_sysreset_n,
  input  wire        bus_sysfail_n,
  input  wire        slot_one_n,
  // Same-clock events
  input  wire        keyboard_reset,
  input  wire        watchdog_expire,
  input  wire        bus_timeout,
  input  wire        dram_write,
  // Bus reset and failure line drive
  output reg         sysreset_o,
  output reg         sysreset_oe_n,
  output reg         sysfail_o,
  output reg         sysfail_oe_n,
  // Board control
  output reg         local_board_reset,
  output reg         selftest_start,
  output reg         soft_boot,
  output reg         master_enable,
  output reg         watchdog_enable,
  output reg         watchdog_count_clear,
  output reg         intgen_clear,
  output reg         slot_one_ctl,
  output reg         bus_timeout_enable,
  // Lamps
  output reg         run_lamp,
  output reg         fail_lamp,
  output reg         test_lamp
);

  // ==================================================
  // States
  localparam [1:0] S_IDLE = 2'b01;
  localparam [1:0] S_HOLD = 2'b10;

  // ==================================================
  // Hold length; the 12-bit counter takes it modulo 4096 cycles
  localparam [11:0] HOLD_LAST = HOLD_CYCLES[11:0] - 12'h001;

  // ==================================================
  // Address decode
  function [2:0] reg_sel;
    input [15:0] a;
    begin
      case (a)
        `BRSC_ADDR_CONFIG:  reg_sel = `BRSC_SEL_CONFIG;
        `BRSC_ADDR_STATCTL: reg_sel = `BRSC_SEL_STATCTL;
        `BRSC_ADDR_EVENT:   reg_sel = `BRSC_SEL_EVENT;
        `BRSC_ADDR_MODCTL:  reg_sel = `BRSC_SEL_MODCTL;
        `BRSC_ADDR_INTGEN:  reg_sel = `BRSC_SEL_INTGEN;
        default:            reg_sel = `BRSC_SEL_NONE;
      endcase
    end
  endfunction

  // ==================================================
  // Declarations
  reg  [5:0]  sync1_reg;
  reg  [5:0]  sync2_reg;
  reg  [5:0]  prev_reg;
  reg  [7:0]  config_reg;
  reg  [7:0]  statctl_reg;
  reg  [7:0]  event_reg;
  reg  [7:0]  modctl_reg;
  reg  [7:0]  intgen_reg;
  reg         like_reg;
  reg         post_hold_reg;
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [11:0] cnt_reg;
  reg  [11:0] cnt_next;
  reg         drive_reg;
  reg         drive_next;
  reg         release_pulse;

  wire [2:0]  wsel;
  wire [2:0]  rsel;
  wire        wr_stat;
  wire        wr_mod;
  wire        rd_mod;
  wire        cold_ev;
  wire        low_lvl;
  wire        btn_lvl;
  wire        bus_edge;
  wire        bus_warm;
  wire        bus_soft;
  wire        soft_active;
  wire        wdt_ev;
  wire        warm_ev;
  wire        hw_ev;
  wire        srr_set;
  wire        soft_enter;
  wire        soft_exit;
  wire        to_hold;
  reg  [7:0]  rd_mux;

  // ==================================================
  // Pin synchronisers; first stage feeds only the second
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
      prev_reg  <= 6'h00;
    end else begin
      sync1_reg <= ~{slot_one_n, bus_sysfail_n, bus_sysreset_n,
                     button_n, supply_dead_n, supply_low_n};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // ==================================================
  // Reset classification
  assign wsel        = reg_sel(reg_addr);
  assign rsel        = wsel;
  assign wr_stat     = reg_wr && (wsel == `BRSC_SEL_STATCTL);
  assign wr_mod      = reg_wr && (wsel == `BRSC_SEL_MODCTL);
  assign rd_mod      = reg_rd && (rsel == `BRSC_SEL_MODCTL);
  assign soft_active = statctl_reg[`BRSC_STAT_SRR] | like_reg;

  assign cold_ev  = sync2_reg[`BRSC_SY_DEAD];
  assign low_lvl  = sync2_reg[`BRSC_SY_LOW];
  assign btn_lvl  = sync2_reg[`BRSC_SY_BTN];
  // Our own drive would loop back, so the edge is masked while driving
  assign bus_edge = sync2_reg[`BRSC_SY_BUS] & ~prev_reg[`BRSC_SY_BUS] &
                    sysreset_oe_n;
  assign bus_warm = bus_edge & statctl_reg[`BRSC_STAT_RSTIN];
  assign bus_soft = bus_edge & ~statctl_reg[`BRSC_STAT_RSTIN];
  assign wdt_ev   = watchdog_expire & modctl_reg[`BRSC_MOD_WDTR] &
                    ~soft_active;
  assign warm_ev  = low_lvl | btn_lvl | bus_warm | wdt_ev;
  assign hw_ev    = cold_ev | warm_ev;

  // A 0 to 1 write of the request, or a bus reset with the input enable clear, enters the soft state
  assign srr_set    = wr_stat & reg_wdata[`BRSC_STAT_SRR] &
                      ~statctl_reg[`BRSC_STAT_SRR];
  assign soft_enter = srr_set | (bus_soft & ~soft_active);
  assign soft_exit  = soft_active & wr_stat &
                      ~reg_wdata[`BRSC_STAT_SRR];

  // ==================================================
  // Sequencer: holds local reset for a minimum time
  always @* begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    drive_next = drive_reg;
    case (state_reg)
      S_IDLE: begin
        if (hw_ev) begin
          state_next = S_HOLD;
          cnt_next   = 12'h000;
          drive_next = cold_ev | wdt_ev |
                       modctl_reg[`BRSC_MOD_SYSRST];
        end
      end
      S_HOLD: begin
        // A source still present restarts the count
        if (hw_ev) begin
          cnt_next   = 12'h000;
          drive_next = drive_reg | cold_ev | wdt_ev;
        end else if (cnt_reg >= HOLD_LAST) begin
          state_next = S_IDLE;
          drive_next = 1'b0;
        end else begin
          cnt_next = cnt_reg + 12'h001;
        end
      end
      default: begin
        state_next = S_IDLE;
        cnt_next   = 12'h000;
        drive_next = 1'b0;
      end
    endcase
  end

  assign to_hold = (state_next == S_HOLD);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      cnt_reg   <= 12'h000;
      drive_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      drive_reg <= drive_next;
    end
  end

  // ==================================================
  // Register file
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      config_reg    <= `BRSC_RST_BYTE;
      statctl_reg   <= `BRSC_RST_BYTE;
      event_reg     <= `BRSC_RST_BYTE;
      modctl_reg    <= `BRSC_RST_BYTE;
      intgen_reg    <= `BRSC_RST_BYTE;
      like_reg      <= 1'b0;
      post_hold_reg <= 1'b1;
    end else if (cold_ev) begin
      // Arbiter fields are cleared here too
      config_reg    <= `BRSC_RST_BYTE;
      statctl_reg   <= `BRSC_RST_BYTE;
      event_reg     <= `BRSC_RST_BYTE;
      modctl_reg    <= `BRSC_RST_BYTE;
      intgen_reg    <= `BRSC_RST_BYTE;
      like_reg      <= 1'b0;
      post_hold_reg <= 1'b1;
    end else if (warm_ev) begin
      // Register writes in a reset cycle are lost
      config_reg    <= config_reg & `BRSC_CONFIG_KEEP;
      modctl_reg    <= modctl_reg & `BRSC_MODCTL_KEEP;
      statctl_reg   <= `BRSC_RST_BYTE;
      // Watchdog flag survives its own reset so sysfail stays up
      event_reg     <= (event_reg & `BRSC_EVENT_KEEP) |
                       {4'h0, wdt_ev, 3'h0};
      intgen_reg    <= `BRSC_RST_BYTE;
      like_reg      <= 1'b0;
      post_hold_reg <= 1'b1;
    end else begin
      if (reg_wr && wsel == `BRSC_SEL_CONFIG)
        config_reg <= reg_wdata;
      if (wr_stat)
        statctl_reg <= reg_wdata;
      if (wr_mod) begin
        modctl_reg <= reg_wdata;
        if (reg_wdata[`BRSC_MOD_PASS])
          post_hold_reg <= 1'b0;
      end
      if (reg_wr && wsel == `BRSC_SEL_INTGEN)
        intgen_reg <= reg_wdata;
      // Write one clears; hardware sets win over the clear
      if (reg_wr && wsel == `BRSC_SEL_EVENT)
        event_reg <= (event_reg & ~reg_wdata) |
                     {6'h00, soft_enter, soft_enter | bus_timeout};
      else if (soft_enter | bus_timeout)
        event_reg <= event_reg |
                     {6'h00, soft_enter, soft_enter | bus_timeout};
      if (rd_mod)
        event_reg[`BRSC_EVT_WDOG] <= 1'b0;
      if (soft_enter) begin
        intgen_reg <= `BRSC_RST_BYTE;
        if (srr_set)
          modctl_reg[`BRSC_MOD_PASS] <= 1'b0;
      end
      if (bus_soft & ~soft_active)
        like_reg <= 1'b1;
      else if (soft_exit)
        like_reg <= 1'b0;
    end
  end

  // ==================================================
  // Read port; data only in the cycle after the strobe
  always @* begin
    case (rsel)
      `BRSC_SEL_CONFIG:  rd_mux = config_reg;
      `BRSC_SEL_STATCTL: rd_mux = {statctl_reg[7:1], soft_active};
      `BRSC_SEL_EVENT:   rd_mux = event_reg;
      `BRSC_SEL_MODCTL:  rd_mux = modctl_reg;
      `BRSC_SEL_INTGEN:  rd_mux = intgen_reg;
      default:           rd_mux = 8'h00;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rd_mux;
    else
      reg_rdata <= 8'h00;
  end

  // ==================================================
  // Outputs
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sysreset_o           <= 1'b0;
      sysreset_oe_n        <= 1'b1;
      sysfail_o            <= 1'b0;
      sysfail_oe_n         <= 1'b1;
      local_board_reset    <= 1'b1;
      selftest_start       <= 1'b0;
      soft_boot            <= 1'b0;
      master_enable        <= 1'b0;
      watchdog_enable      <= 1'b0;
      watchdog_count_clear <= 1'b0;
      intgen_clear         <= 1'b0;
      slot_one_ctl         <= 1'b0;
      bus_timeout_enable   <= 1'b0;
      run_lamp             <= 1'b0;
      fail_lamp            <= 1'b1;
      test_lamp            <= 1'b1;
      release_pulse        <= 1'b0;
    end else begin
      // Open-drain data stays low; only the enables move
      sysreset_o        <= 1'b0;
      sysreset_oe_n     <= ~(to_hold & drive_next);
      sysfail_o         <= 1'b0;
      sysfail_oe_n      <= ~(event_reg[`BRSC_EVT_WDOG] |
                             (soft_active &
                              ~statctl_reg[`BRSC_STAT_INHIBIT]));
      local_board_reset <= to_hold;
      release_pulse     <= (state_reg == S_HOLD) & ~to_hold;
      selftest_start    <= release_pulse;
      // Keyboard reset touches no register or reset line
      soft_boot         <= keyboard_reset;
      master_enable     <= statctl_reg[`BRSC_STAT_MASTER] &
                           ~soft_active & ~to_hold;
      watchdog_enable   <= modctl_reg[`BRSC_MOD_WDTR] &
                           ~soft_active;
      watchdog_count_clear <= rd_mod | soft_exit;
      intgen_clear      <= soft_enter;
      // Slot-one control and bus timeout enable unaffected by the soft request
      slot_one_ctl       <= sync2_reg[`BRSC_SY_SLOT];
      bus_timeout_enable <= modctl_reg[`BRSC_MOD_BTOE];
      run_lamp  <= dram_write;
      fail_lamp <= (sync2_reg[`BRSC_SY_SLOT] &
                    sync2_reg[`BRSC_SY_FAIL]) |
                   post_hold_reg | to_hold;
      test_lamp <= ~modctl_reg[`BRSC_MOD_PASS];
    end
  end

endmodule

// [logic/brsc_defs.vh]
// Constants for the board reset and soft reset controller
`ifndef BRSC_DEFS_VH
`define BRSC_DEFS_VH

// ==================================================
// Register addresses
`define BRSC_ADDR_CONFIG   16'h8102
`define BRSC_ADDR_STATCTL  16'h8144
`define BRSC_ADDR_EVENT    16'h8154
`define BRSC_ADDR_MODCTL   16'h815d
`define BRSC_ADDR_INTGEN   16'h815f

// ==================================================
// Register select codes
`define BRSC_SEL_NONE      3'h0
`define BRSC_SEL_CONFIG    3'h1
`define BRSC_SEL_STATCTL   3'h2
`define BRSC_SEL_EVENT     3'h3
`define BRSC_SEL_MODCTL    3'h4
`define BRSC_SEL_INTGEN    3'h5

// ==================================================
// Field positions
`define BRSC_STAT_SRR      0
`define BRSC_STAT_INHIBIT  1
`define BRSC_STAT_MASTER   2
`define BRSC_STAT_RSTIN    7
`define BRSC_EVT_BERR      0
`define BRSC_EVT_REMOTE    1
`define BRSC_EVT_WDOG      3
`define BRSC_MOD_PASS      2
`define BRSC_MOD_WDTR      3
`define BRSC_MOD_BTOE      4
`define BRSC_MOD_SYSRST    6

// ==================================================
// Reset values and warm-reset keep masks
`define BRSC_RST_BYTE      8'h00
`define BRSC_CONFIG_KEEP   8'hf0
`define BRSC_MODCTL_KEEP   8'h56
`define BRSC_EVENT_KEEP    8'h08

// ==================================================
// Timing
`define BRSC_CLK_PERIOD_NS 10
`define BRSC_RESET_HOLD_NS 1000

// ==================================================
// Synchroniser lanes
`define BRSC_SY_LOW        0
`define BRSC_SY_DEAD       1
`define BRSC_SY_BTN        2
`define BRSC_SY_BUS        3
`define BRSC_SY_FAIL       4
`define BRSC_SY_SLOT       5

`endif

// [sim/brsc_core_props.sv]
// Port assertions for the board reset and soft reset controller
`timescale 1ns/1ps
module brsc_core_props #(
  parameter HOLD_CYCLES = 100
) (
  // Clock and power-on reset
  input wire clk,
  input wire rst_n,
  // Sources and events
  input wire supply_low_n,
  input wire supply_dead_n,
  input wire button_n,
  input wire bus_sysreset_n,
  input wire bus_sysfail_n,
  input wire slot_one_n,
  input wire keyboard_reset,
  input wire watchdog_expire,
  input wire dram_write,
  // Watched outputs
  input wire sysreset_oe_n,
  input wire sysfail_oe_n,
  input wire local_board_reset,
  input wire soft_boot,
  input wire master_enable,
  input wire watchdog_enable,
  input wire intgen_clear,
  input wire slot_one_ctl,
  input wire run_lamp,
  input wire fail_lamp
);
  // ==================================================
  // Hold length; power-on counts as a full hold
  reg [15:0] hcnt_reg;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      hcnt_reg <= 16'(HOLD_CYCLES);
    else if (local_board_reset)
      hcnt_reg <= hcnt_reg + 16'h1;
    else
      hcnt_reg <= 16'h0;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==================================================
  // Assertions
  a_run_lamp: assert property (dram_write |=> run_lamp)
    else $error("run lamp missed a write");
  a_kbd_boot: assert property (keyboard_reset |=> soft_boot)
    else $error("keyboard sequence gave no soft boot");
  a_kbd_no_reset: assert property ((button_n && supply_low_n && supply_dead_n &&
      bus_sysreset_n && !watchdog_expire && !local_board_reset)[*6] ##0 keyboard_reset
      |=> !local_board_reset && sysreset_oe_n)
    else $error("keyboard sequence caused a hardware reset");
  a_button_warm: assert property (!button_n [*4] |-> local_board_reset)
    else $error("button gave no local reset");
  a_low_supply: assert property (!supply_low_n [*4] |-> local_board_reset)
    else $error("low supply gave no local reset");
  a_cold_drive: assert property (!supply_dead_n [*4]
      |-> local_board_reset && !sysreset_oe_n)
    else $error("cold reset without bus reset drive");
  a_hold_len: assert property ($fell(local_board_reset) |-> hcnt_reg >= HOLD_CYCLES)
    else $error("local reset hold too short");
  a_wdog_drive: assert property (watchdog_expire && watchdog_enable
      |-> ##[1:3] (!sysfail_oe_n && !sysreset_oe_n))
    else $error("watchdog reset without failure and reset drive");
  a_slot_fail: assert property ((!slot_one_n && !bus_sysfail_n)[*4] |-> fail_lamp)
    else $error("fail lamp dark while failure line asserted");
  a_reset_lamp: assert property (local_board_reset |-> fail_lamp)
    else $error("fail lamp dark during hardware reset");
  a_soft_entry: assert property (intgen_clear |=> !master_enable && !watchdog_enable)
    else $error("soft state left master or watchdog enabled");
  a_slot_ctl: assert property (!slot_one_n [*4] |-> slot_one_ctl)
    else $error("slot one control not following jumper");

  c_soft: cover property (intgen_clear);
  c_hold_end: cover property ($fell(local_board_reset));
  c_wdog: cover property (watchdog_expire && watchdog_enable);
endmodule

// [sim/brsc_bus_model.sv]
// Backplane model: pulled-up reset and failure lines shared with other boards
`timescale 1ns/1ps
module brsc_bus_model (
  // Drivers of the board under test
  input  wire sysreset_o,
  input  wire sysreset_oe_n,
  input  wire sysfail_o,
  input  wire sysfail_oe_n,
  // Other boards pulling the lines low
  input  wire other_reset,
  input  wire other_fail,
  // Resolved wired-or lines
  output wire bus_sysreset_n,
  output wire bus_sysfail_n
);
  // Released lines float back high through the pull-ups
  assign bus_sysreset_n = ~other_reset & (sysreset_oe_n | sysreset_o);
  assign bus_sysfail_n  = ~other_fail & (sysfail_oe_n | sysfail_o);
endmodule

// [sim/board_reset_and_soft_reset_control_tb.sv]
// Self-checking bench for the board reset and soft reset controller
`timescale 1ns/1ps
`include "brsc_defs.vh"
module board_reset_and_soft_reset_control_tb;
  // ==================================================
  // Stimulus, outputs and model state
  logic        clk, rst_n, reg_wr, reg_rd, keyboard_reset, watchdog_expire, bus_timeout;
  logic        supply_low_n, supply_dead_n, button_n, slot_one_n, dram_write;
  logic        oth_rst, oth_fail;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, cfg, mod;
  wire  [7:0]  reg_rdata;
  wire         bus_sysreset_n, bus_sysfail_n, sysreset_o, sysreset_oe_n, sysfail_o;
  wire         sysfail_oe_n, local_board_reset, selftest_start, soft_boot, master_enable;
  wire         watchdog_enable, watchdog_count_clear, intgen_clear, slot_one_ctl;
  wire         bus_timeout_enable, run_lamp, fail_lamp, test_lamp;
  int          n_mismatch = 0, cmp_count = 0, cyc = 0, n_start = 0, i, j;
  logic [31:0] seed = 32'h1ee7bd45;
  logic [15:0] amap[$] = '{`BRSC_ADDR_CONFIG, `BRSC_ADDR_STATCTL, `BRSC_ADDR_EVENT,
                           `BRSC_ADDR_MODCTL, `BRSC_ADDR_INTGEN, 16'h8100};

  // Short hold keeps each hardware reset brief
  brsc_core #(.HOLD_CYCLES(4)) dut_u (.*);
  brsc_bus_model bus_u (
    .sysreset_o    (sysreset_o),
    .sysreset_oe_n (sysreset_oe_n),
    .sysfail_o     (sysfail_o),
    .sysfail_oe_n  (sysfail_oe_n),
    .other_reset   (oth_rst),
    .other_fail    (oth_fail),
    .bus_sysreset_n(bus_sysreset_n),
    .bus_sysfail_n (bus_sysfail_n)
  );

  // ==================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Strobes end with a 1 ns pause so back-to-back calls never share a time step
  task wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("read %h", a), e, reg_rdata);
  endtask
  task wait_idle;
    int k;
    step(4);
    for (k = 0; k < 400 && local_board_reset !== 1'b0; k++)
      step(1);
    chk("local_board_reset", 8'h00, 8'(local_board_reset));
    step(2);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    dram_write <= (xs() & 32'h1) != 0;
    if (selftest_start === 1'b1)
      n_start <= n_start + 1;
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_mismatch++;
      end_sim;
    end
  end

  // ==================================================
  // Main sequence
  initial begin
    {rst_n, reg_wr, reg_rd, keyboard_reset, watchdog_expire, bus_timeout} = '0;
    {oth_rst, oth_fail, reg_addr, reg_wdata} = '0;
    {supply_low_n, supply_dead_n, button_n, slot_one_n} = '1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    step(1);
    foreach (amap[k]) rd(amap[k], 8'h00);
    for (i = 0; i < 2; i++) begin
      cfg = 8'(xs());
      mod = 8'(xs()) & 8'hb7 | 8'(i << 6);
      wr(`BRSC_ADDR_CONFIG, cfg);
      wr(`BRSC_ADDR_MODCTL, mod);
      button_n <= 1'b0;
      step(6);
      chk("sysreset_oe_n", 8'(!mod[6]), 8'(sysreset_oe_n));
      button_n <= 1'b1;
      wait_idle;
      cfg = cfg & 8'hf0;
      mod = mod & 8'h56;
      rd(`BRSC_ADDR_CONFIG, cfg);
      rd(`BRSC_ADDR_MODCTL, mod);
      chk("test_lamp", 8'(!mod[2]), 8'(test_lamp));
      chk("bus_timeout_enable", 8'(mod[4]), 8'(bus_timeout_enable));
    end
    for (j = 0; j < 2; j++) begin
      wr(`BRSC_ADDR_MODCTL, 8'h04);
      wr(`BRSC_ADDR_INTGEN, 8'h5a);
      wr(`BRSC_ADDR_STATCTL, 8'h04);
      wr(`BRSC_ADDR_STATCTL, 8'h05 | 8'(j << 1));
      step(2);
      chk("sysfail_oe_n", 8'(j), 8'(sysfail_oe_n));
      chk("master_enable", 8'h00, 8'(master_enable));
      chk("test_lamp", 8'h01, 8'(test_lamp));
      rd(`BRSC_ADDR_EVENT, 8'h03);
      rd(`BRSC_ADDR_INTGEN, 8'h00);
      rd(`BRSC_ADDR_MODCTL, 8'h00);
      wr(`BRSC_ADDR_STATCTL, 8'h04);
      chk("watchdog_count_clear", 8'h01, 8'(watchdog_count_clear));
      step(1);
      chk("master_enable", 8'h01, 8'(master_enable));
      wr(`BRSC_ADDR_EVENT, 8'h03);
      rd(`BRSC_ADDR_EVENT, 8'h00);
    end
    bus_timeout <= 1'b1;
    step(1);
    bus_timeout <= 1'b0;
    rd(`BRSC_ADDR_EVENT, 8'h01);
    wr(`BRSC_ADDR_EVENT, 8'h01);
    // Bus reset first without, then with the input enable
    wr(`BRSC_ADDR_MODCTL, 8'h04);
    wr(`BRSC_ADDR_STATCTL, 8'h00);
    for (j = 0; j < 2; j++) begin
      oth_rst <= 1'b1;
      step(6);
      chk("local_board_reset", 8'(j), 8'(local_board_reset));
      oth_rst <= 1'b0;
      if (j == 0) begin
        step(2);
        chk("test_lamp", 8'h00, 8'(test_lamp));
        rd(`BRSC_ADDR_STATCTL, 8'h01);
        wr(`BRSC_ADDR_STATCTL, 8'h81);
        wr(`BRSC_ADDR_MODCTL, 8'h04);
      end
    end
    wait_idle;
    rd(`BRSC_ADDR_STATCTL, 8'h00);
    rd(`BRSC_ADDR_EVENT, 8'h00);
    rd(`BRSC_ADDR_MODCTL, 8'h04);
    wr(`BRSC_ADDR_MODCTL, 8'h08);
    step(1);
    watchdog_expire <= 1'b1;
    step(1);
    watchdog_expire <= 1'b0;
    wait_idle;
    chk("sysfail_oe_n", 8'h00, 8'(sysfail_oe_n));
    rd(`BRSC_ADDR_EVENT, 8'h08);
    rd(`BRSC_ADDR_MODCTL, 8'h00);
    step(2);
    chk("sysfail_oe_n", 8'h01, 8'(sysfail_oe_n));
    keyboard_reset <= 1'b1;
    step(1);
    keyboard_reset <= 1'b0;
    chk("soft_boot", 8'h01, 8'(soft_boot));
    step(4);
    rd(`BRSC_ADDR_CONFIG, cfg);
    wr(`BRSC_ADDR_MODCTL, 8'h04);
    step(2);
    chk("fail_lamp", 8'h00, 8'(fail_lamp));
    slot_one_n <= 1'b0;
    oth_fail <= 1'b1;
    step(5);
    chk("fail_lamp", 8'h01, 8'(fail_lamp));
    chk("slot_one_ctl", 8'h01, 8'(slot_one_ctl));
    oth_fail <= 1'b0;
    supply_low_n <= 1'b0;
    step(6);
    supply_low_n <= 1'b1;
    wait_idle;
    rd(`BRSC_ADDR_CONFIG, cfg);
    supply_dead_n <= 1'b0;
    step(6);
    chk("sysreset_oe_n", 8'h00, 8'(sysreset_oe_n));
    supply_dead_n <= 1'b1;
    wait_idle;
    rd(`BRSC_ADDR_CONFIG, 8'h00);
    chk("selftest_start count", 8'h06, 8'(n_start));
    end_sim;
  end
endmodule

bind brsc_core brsc_core_props #(.HOLD_CYCLES(HOLD_CYCLES)) prop_u (.*);
